// ==== design/lsb_status_bank.v ====
// Status and fault register bank of a twelve-switch bypass manager.
// Assumes the serial front end decodes frames and hands over a register
// access strobe plus one-cycle error events; analog conditions arrive as pins.
`timescale 1ns/100ps
`default_nettype none
`include "lsb_regs.vh"
module lsb_status_bank #(
  parameter N_SW = 12,
  parameter BIT_CYCLES = 16'd0868,
  parameter IDLE_UNIT = 24'd0100000
) (
  input wire mclk,
  input wire reset_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [5:0] reg_addr,
  input wire [12:0] reg_wdata,
  output reg [12:0] reg_rdata,
  output reg reg_rvalid,
  input wire rx_in,
  input wire frame_crc_bad,
  input wire sync_parity_bad,
  input wire payload_parity_bad,
  input wire sync_stop_bad,
  input wire payload_stop_bad,
  input wire payload_start_bad,
  input wire otp_crc_mismatch,
  input wire setup_prog_done,
  input wire grade_decode_done,
  input wire [3:0] grade_code,
  input wire ext_ref_slow,
  input wire pump_voltage_low,
  input wire overheat_shutdown,
  input wire overheat_warning,
  input wire [N_SW-1:0] open_detect,
  input wire [N_SW-1:0] short_detect,
  input wire [N_SW-1:0] slew_busy,
  input wire [N_SW*12-1:0] duty_flat,
  input wire [7:0] thermistor_ratio,
  input wire [N_SW-1:0] group_a_members,
  input wire [N_SW-1:0] group_b_members,
  output reg fault_out_n,
  output reg crc_reject,
  output reg idle_safe_state
);
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  reg [6:0] pin_s1_q;
  reg [6:0] pin_s2_q;
  wire rx_s;
  wire ext_slow_s;
  wire pump_low_s;
  wire shdn_s;
  wire warn_s;
  wire decode_done_s;
  wire otp_bad_s;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // Idle levels, so no sticky flag latches a false event at release
      pin_s1_q <= `LSB_RST_PINS;
      pin_s2_q <= `LSB_RST_PINS;
    end else begin
      pin_s1_q <= {rx_in, ext_ref_slow, pump_voltage_low, overheat_shutdown,
                   overheat_warning, grade_decode_done, otp_crc_mismatch};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign rx_s = pin_s2_q[6];
  assign ext_slow_s = pin_s2_q[5];
  assign pump_low_s = pin_s2_q[4];
  assign shdn_s = pin_s2_q[3];
  assign warn_s = pin_s2_q[2];
  assign decode_done_s = pin_s2_q[1];
  assign otp_bad_s = pin_s2_q[0];

  // ----------------------------------------------------------------------
  // Writable control registers
  // ----------------------------------------------------------------------
  reg [12:0] gen_setup_q;
  reg [12:0] ser_setup_q;
  reg [12:0] mask_gen_q;
  reg [N_SW-1:0] mask_sw_q;
  reg [11:0] min_duty_q;
  reg [9:0] grp_phase_q;
  wire wr_hit_w;

  function hit;
    input [5:0] a;
    input [5:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign wr_hit_w = reg_wr;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gen_setup_q <= `LSB_RST_ZERO;
      ser_setup_q <= `LSB_RST_ZERO;
      mask_gen_q <= `LSB_RST_ZERO;
      mask_sw_q <= {N_SW{1'b0}};
      min_duty_q <= `LSB_RST_MIN_DUTY;
      grp_phase_q <= `LSB_RST_GRP_PHASE;
    end else if (wr_hit_w) begin
      if (hit(reg_addr, `LSB_OFS_GEN_SETUP)) gen_setup_q <= reg_wdata;
      if (hit(reg_addr, `LSB_OFS_SER_SETUP)) ser_setup_q <= reg_wdata;
      if (hit(reg_addr, `LSB_OFS_MASK_GEN)) mask_gen_q <= reg_wdata;
      if (hit(reg_addr, `LSB_OFS_MASK_SW)) mask_sw_q <= reg_wdata[N_SW-1:0];
      if (hit(reg_addr, `LSB_OFS_MIN_DUTY)) min_duty_q <= reg_wdata[11:0];
      if (hit(reg_addr, `LSB_OFS_GRP_PHASE)) grp_phase_q <= reg_wdata[9:0];
    end
  end

  // ----------------------------------------------------------------------
  // Setup pending and group phase write
  // ----------------------------------------------------------------------
  reg setup_pend_q;
  wire [N_SW-1:0] phase_mask_w;
  wire [7:0] phase_rd_w;
  wire grp_wr_w;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      setup_pend_q <= 1'b0;
    end else if (reg_wr && hit(reg_addr, `LSB_OFS_GEN_SETUP)) begin
      setup_pend_q <= 1'b1;
    end else if (setup_prog_done) begin
      setup_pend_q <= 1'b0;
    end
  end

  // A select of 00 leaves every phase untouched
  assign grp_wr_w = reg_wr && hit(reg_addr, `LSB_OFS_GRP_PHASE);
  assign phase_mask_w = grp_wr_w ?
    (({N_SW{reg_wdata[`LSB_GP_SEL_A]}} & group_a_members) |
     ({N_SW{reg_wdata[`LSB_GP_SEL_B]}} & group_b_members)) : {N_SW{1'b0}};

  lsb_phase_mem #(.N(N_SW)) u_phase (
    .mclk(mclk),
    .reset_n(reset_n),
    .wr_mask(phase_mask_w),
    .wr_data(reg_wdata[7:0]),
    .rd_idx(reg_addr[3:0] - 4'd1),
    .rd_data(phase_rd_w)
  );

  // ----------------------------------------------------------------------
  // Receive line idle timers
  // ----------------------------------------------------------------------
  reg rx_prev_q;
  reg [15:0] bit_cnt_q;
  reg [4:0] silent_bits_q;
  reg [23:0] unit_cnt_q;
  reg [7:0] idle_units_q;
  wire rx_edge_w;
  wire bit_tick_w;
  wire unit_tick_w;
  wire timeout_hit_w;
  wire idle_hit_w;
  wire [7:0] idle_limit_w;

  assign rx_edge_w = rx_s ^ rx_prev_q;
  assign bit_tick_w = (bit_cnt_q == BIT_CYCLES - 16'd1);
  assign unit_tick_w = (unit_cnt_q == IDLE_UNIT - 24'd1);
  assign idle_limit_w = ser_setup_q[7:0];
  assign timeout_hit_w = bit_tick_w && (silent_bits_q == `LSB_TIMEOUT_BITS);
  assign idle_hit_w = unit_tick_w && (idle_limit_w != 8'h00) &&
                      (idle_units_q == idle_limit_w - 8'd1);

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_prev_q <= 1'b1;
      bit_cnt_q <= 16'h0000;
      silent_bits_q <= 5'h00;
      unit_cnt_q <= 24'h00_0000;
      idle_units_q <= 8'h00;
    end else begin
      rx_prev_q <= rx_s;
      if (rx_edge_w) begin
        bit_cnt_q <= 16'h0000;
        silent_bits_q <= 5'h00;
        unit_cnt_q <= 24'h00_0000;
        idle_units_q <= 8'h00;
      end else begin
        bit_cnt_q <= bit_tick_w ? 16'h0000 : bit_cnt_q + 16'd1;
        if (bit_tick_w && silent_bits_q <= `LSB_TIMEOUT_BITS)
          silent_bits_q <= silent_bits_q + 5'd1;
        unit_cnt_q <= unit_tick_w ? 24'h00_0000 : unit_cnt_q + 24'd1;
        if (unit_tick_w && idle_units_q != 8'hFF)
          idle_units_q <= idle_units_q + 8'd1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sticky flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------------
  reg [8:1] ser_flags_q;
  reg [N_SW-1:0] short_q;
  reg [N_SW-1:0] open_q;
  reg shdn_q;
  reg warn_q;
  reg crc_err_q;
  wire [8:1] ser_set_w;
  wire [N_SW-1:0] short_set_w;
  wire [N_SW-1:0] clr_short_w;
  wire [N_SW-1:0] clr_open_w;
  wire [8:1] clr_ser_w;
  wire clr_gen_w;
  genvar g;

  assign ser_set_w = {idle_hit_w, timeout_hit_w, frame_crc_bad,
                      sync_parity_bad, payload_parity_bad,
                      sync_stop_bad, payload_stop_bad, payload_start_bad};
  assign clr_ser_w = (reg_wr && hit(reg_addr, `LSB_OFS_SER_STAT)) ?
                     reg_wdata[8:1] : 8'h00;
  assign clr_short_w = (reg_wr && hit(reg_addr, `LSB_OFS_SHORT)) ?
                       reg_wdata[N_SW-1:0] : {N_SW{1'b0}};
  assign clr_open_w = (reg_wr && hit(reg_addr, `LSB_OFS_OPEN)) ?
                      reg_wdata[N_SW-1:0] : {N_SW{1'b0}};
  assign clr_gen_w = reg_wr && hit(reg_addr, `LSB_OFS_GEN_STAT);

  generate
    for (g = 0; g < N_SW; g = g + 1) begin : g_short
      // Below minimum duty or still slewing the switch voltage is not settled
      assign short_set_w[g] = short_detect[g] && !slew_busy[g] &&
                              (duty_flat[g*12 +: 12] >= min_duty_q);
    end
  endgenerate

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ser_flags_q <= 8'h00;
      short_q <= {N_SW{1'b0}};
      open_q <= {N_SW{1'b0}};
      shdn_q <= 1'b0;
      warn_q <= 1'b0;
      crc_err_q <= 1'b0;
      crc_reject <= 1'b0;
      idle_safe_state <= 1'b0;
    end else begin
      ser_flags_q <= (ser_flags_q & ~clr_ser_w) | ser_set_w;
      short_q <= (short_q & ~clr_short_w) | short_set_w;
      open_q <= (open_q & ~clr_open_w) | open_detect;
      shdn_q <= (shdn_q & ~(clr_gen_w & reg_wdata[`LSB_GS_SHDN])) | shdn_s;
      warn_q <= (warn_q & ~(clr_gen_w & reg_wdata[`LSB_GS_WARN])) | warn_s;
      crc_err_q <= crc_err_q | otp_bad_s;
      crc_reject <= frame_crc_bad;
      if (timeout_hit_w)
        idle_safe_state <= 1'b1;
      else if (rx_edge_w)
        idle_safe_state <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // General status word and fault output
  // ----------------------------------------------------------------------
  reg [12:0] gen_stat_w;
  wire ref_in_used_w;

  assign ref_in_used_w = gen_setup_q[`LSB_CLKSEL_LSB + 1];

  always @* begin
    gen_stat_w = `LSB_RST_ZERO;
    gen_stat_w[`LSB_GS_CRC] = crc_err_q;
    gen_stat_w[`LSB_GS_SETUP] = setup_pend_q;
    gen_stat_w[`LSB_GS_DECODE] = !decode_done_s;
    gen_stat_w[`LSB_GS_REFSLOW] = ref_in_used_w && ext_slow_s;
    gen_stat_w[`LSB_GS_SERERR] = |ser_flags_q;
    gen_stat_w[`LSB_GS_OPEN] = |open_q;
    gen_stat_w[`LSB_GS_SHORT] = |short_q;
    gen_stat_w[`LSB_GS_PUMP] = pump_low_s;
    gen_stat_w[`LSB_GS_SHDN] = shdn_q;
    gen_stat_w[`LSB_GS_WARN] = warn_q;
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fault_out_n <= 1'b1;
    end else begin
      // Per-switch mask removes unpopulated positions; bits 10, 9 never fault
      fault_out_n <= !((gen_stat_w[`LSB_GS_DECODE] && !mask_gen_q[1]) ||
                       (gen_stat_w[`LSB_GS_REFSLOW]) ||
                       (gen_stat_w[`LSB_GS_SERERR] && !mask_gen_q[6]) ||
                       (|(open_q & ~mask_sw_q) && !mask_gen_q[4]) ||
                       (|(short_q & ~mask_sw_q) && !mask_gen_q[3]) ||
                       (pump_low_s && !mask_gen_q[2]) ||
                       shdn_q ||
                       (warn_q && !mask_gen_q[0]));
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  reg [12:0] rd_mux_w;
  reg phase_rd_q;

  always @* begin
    case (reg_addr)
      `LSB_OFS_GEN_SETUP: rd_mux_w = gen_setup_q;
      `LSB_OFS_SER_SETUP: rd_mux_w = ser_setup_q;
      `LSB_OFS_MASK_GEN: rd_mux_w = mask_gen_q;
      `LSB_OFS_MASK_SW: rd_mux_w = {1'b0, mask_sw_q};
      `LSB_OFS_GRADE: rd_mux_w = {9'h000, grade_code};
      `LSB_OFS_GEN_STAT: rd_mux_w = gen_stat_w;
      `LSB_OFS_SER_STAT: rd_mux_w = {4'h0, ser_flags_q, 1'b0};
      `LSB_OFS_SHORT: rd_mux_w = {1'b0, short_q};
      `LSB_OFS_OPEN: rd_mux_w = {1'b0, open_q};
      `LSB_OFS_THERM: rd_mux_w = {5'h00, thermistor_ratio};
      `LSB_OFS_MIN_DUTY: rd_mux_w = {1'b0, min_duty_q};
      `LSB_OFS_GRP_PHASE: rd_mux_w = {3'h0, grp_phase_q};
      default: rd_mux_w = 13'h0000;
    endcase
  end

  // Phase words come from the memory one cycle later, so phase reads answer
  // two edges after the strobe and every other read one edge after it.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 13'h0000;
      reg_rvalid <= 1'b0;
      phase_rd_q <= 1'b0;
    end else begin
      phase_rd_q <= reg_rd && (reg_addr >= `LSB_OFS_PHASE_BASE) &&
                    (reg_addr < `LSB_OFS_PHASE_BASE + 6'd12);
      reg_rvalid <= phase_rd_q || (reg_rd && !((reg_addr >= `LSB_OFS_PHASE_BASE) &&
                    (reg_addr < `LSB_OFS_PHASE_BASE + 6'd12)));
      if (phase_rd_q)
        reg_rdata <= {5'h00, phase_rd_w};
      else if (reg_rd)
        reg_rdata <= rd_mux_w;
    end
  end
endmodule // lsb_status_bank
`default_nettype wire

// ==== design/lsb_regs.vh ====
// Register offsets, field positions, reset values and timing counts for the
// status and fault bank. Definitions only.
`ifndef LSB_REGS_VH
`define LSB_REGS_VH

`define LSB_ADDR_W 6
`define LSB_DATA_W 13
// Offsets
`define LSB_OFS_GEN_SETUP 6'h00
`define LSB_OFS_SER_SETUP 6'h01
`define LSB_OFS_MASK_GEN 6'h0C
`define LSB_OFS_MASK_SW 6'h0D
`define LSB_OFS_GRADE 6'h0F
`define LSB_OFS_GEN_STAT 6'h10
`define LSB_OFS_SER_STAT 6'h11
`define LSB_OFS_SHORT 6'h12
`define LSB_OFS_OPEN 6'h13
`define LSB_OFS_THERM 6'h15
`define LSB_OFS_MIN_DUTY 6'h16
`define LSB_OFS_GRP_PHASE 6'h20
`define LSB_OFS_PHASE_BASE 6'h21
// General status bit positions
`define LSB_GS_CRC 10
`define LSB_GS_SETUP 9
`define LSB_GS_DECODE 8
`define LSB_GS_REFSLOW 7
`define LSB_GS_SERERR 6
`define LSB_GS_OPEN 4
`define LSB_GS_SHORT 3
`define LSB_GS_PUMP 2
`define LSB_GS_SHDN 1
`define LSB_GS_WARN 0
// Serial status bit positions
`define LSB_SS_IDLE 8
`define LSB_SS_TIMEOUT 7
`define LSB_SS_CRC 6
`define LSB_SS_SYNC_PAR 5
`define LSB_SS_PL_PAR 4
`define LSB_SS_SYNC_STOP 3
`define LSB_SS_PL_STOP 2
`define LSB_SS_PL_START 1
// Group phase fields
`define LSB_GP_SEL_A 8
`define LSB_GP_SEL_B 9
// Reset values
`define LSB_RST_MIN_DUTY 12'h0010
`define LSB_RST_ZERO 13'h0000
`define LSB_RST_GRP_PHASE 10'h100
// Synchroniser reset: receive line idles high, every other pin idles low
`define LSB_RST_PINS 7'h40
// Timing: bit periods of receive silence, less one, before the timeout flag
`define LSB_TIMEOUT_BITS 16
// Clock source select field in general setup
`define LSB_CLKSEL_LSB 4

`endif

// ==== design/lsb_phase_mem.v ====
// Per-switch phase memory: twelve 8-bit words with registered read data.
// Assumes a single clock; group write updates every word whose mask bit is set.
`timescale 1ns/100ps
`default_nettype none
module lsb_phase_mem #(
  parameter N = 12
) (
  input wire mclk,
  input wire reset_n,
  input wire [N-1:0] wr_mask,
  input wire [7:0] wr_data,
  input wire [3:0] rd_idx,
  output reg [7:0] rd_data
);
  reg [7:0] mem_q [0:N-1];
  integer i;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < N; i = i + 1) begin
        mem_q[i] <= 8'h00;
      end
      rd_data <= 8'h00;
    end else begin
      for (i = 0; i < N; i = i + 1) begin
        if (wr_mask[i]) begin
          mem_q[i] <= wr_data;
        end
      end
      rd_data <= (rd_idx < N) ? mem_q[rd_idx] : 8'h00;
    end
  end
endmodule // lsb_phase_mem
`default_nettype wire

// ==== bench/lsb_status_bank_props.sv ====
// Port checks for the status and fault bank.
// Assumes one clock and register strobes driven by the host model.
`timescale 1ns/100ps
`default_nettype none
module lsb_status_bank_props #(
  parameter N_SW = 12
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [12:0] reg_rdata,
  input wire logic rx_in,
  input wire logic frame_crc_bad,
  input wire logic sync_parity_bad,
  input wire logic setup_prog_done,
  input wire logic pump_voltage_low,
  input wire logic overheat_shutdown,
  input wire logic [N_SW-1:0] open_detect,
  input wire logic [7:0] thermistor_ratio,
  input wire logic fault_out_n,
  input wire logic crc_reject,
  input wire logic idle_safe_state
);
  logic [7:0] quiet_q;
  logic [2:0] steady_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Saturating counts, so old history never wraps into a false match
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      quiet_q <= 8'h00;
      steady_q <= 3'h0;
    end else begin
      quiet_q <= $changed(rx_in) ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hFF};
      steady_q <= $changed(pump_voltage_low) ? 3'h0 : steady_q + {2'h0, steady_q != 3'h7};
    end
  end
  sequence s_sync_fault;
    sync_parity_bad ##[1:3] (reg_rd && reg_addr == 6'h11);
  endsequence
  sequence s_setup_write;
    (reg_wr && reg_addr == 6'h00) ##1 !setup_prog_done
      ##1 (reg_rd && reg_addr == 6'h10 && !setup_prog_done);
  endsequence
  sequence s_open_seen;
    (|open_detect) ##2 (reg_rd && reg_addr == 6'h10);
  endsequence
  crc_reject_pulse_a: assert property (crc_reject == $past(frame_crc_bad))
    else $error("reject pulse does not follow bad check code");
  therm_read_a: assert property (reg_rd && reg_addr == 6'h15 |=>
    reg_rdata == {5'h00, $past(thermistor_ratio)}) else $error("ratio read wrong");
  sync_flag_a: assert property (s_sync_fault |=> reg_rdata[5])
    else $error("sync parity flag missing");
  setup_pend_a: assert property (s_setup_write |=> reg_rdata[9])
    else $error("setup pending bit missing");
  open_summary_a: assert property (s_open_seen |=> reg_rdata[4])
    else $error("open summary bit missing");
  shdn_fault_a: assert property (overheat_shutdown [*4] |=> !fault_out_n)
    else $error("fault output not low on shutdown");
  pump_live_a: assert property (reg_rd && reg_addr == 6'h10 && steady_q == 3'h7 |=>
    reg_rdata[2] == $past(pump_voltage_low)) else $error("pump bit not live");
  idle_clear_a: assert property ($changed(rx_in) |-> ##[1:5] !idle_safe_state)
    else $error("idle state kept after receive edge");
  idle_late_a: assert property ($rose(idle_safe_state) |-> quiet_q > 8'd64)
    else $error("idle state too early");
  idle_bound_a: assert property (quiet_q == 8'd90 |-> idle_safe_state)
    else $error("idle state too late");
endmodule // lsb_status_bank_props
bind lsb_status_bank lsb_status_bank_props #(.N_SW(N_SW)) u_props (
  .mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .rx_in(rx_in),
  .frame_crc_bad(frame_crc_bad), .sync_parity_bad(sync_parity_bad),
  .setup_prog_done(setup_prog_done), .pump_voltage_low(pump_voltage_low),
  .overheat_shutdown(overheat_shutdown), .open_detect(open_detect),
  .thermistor_ratio(thermistor_ratio), .fault_out_n(fault_out_n),
  .crc_reject(crc_reject), .idle_safe_state(idle_safe_state)
);
`default_nettype wire

// ==== bench/lsb_host_model.sv ====
// Host side of the register strobes: one access at a time.
// Assumes the bank answers a read within four edges.
`timescale 1ns/100ps
`default_nettype none
module lsb_host_model (
  input wire logic mclk,
  input wire logic [12:0] reg_rdata,
  input wire logic reg_rvalid,
  output var logic reg_wr,
  output var logic reg_rd,
  output var logic [5:0] reg_addr,
  output var logic [12:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 13'h0000;
  end
  task automatic wr(input logic [5:0] a, input logic [12:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // Released data must not look valid
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [12:0] d, output logic ok);
    int i;
    ok = 1'b0;
    d = 13'h0000;
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    for (i = 0; i < 4 && !ok; i++) begin
      #1;
      ok = reg_rvalid === 1'b1;
      d = reg_rdata;
      if (!ok) @(posedge mclk);
    end
  endtask
  task automatic setup_wr(input logic [12:0] d, output logic ok);
    logic [12:0] s;
    int n;
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      rd(6'h10, s, ok);
      ok = ok && s[9] === 1'b0;
    end
    if (ok) wr(6'h00, d);
  endtask
endmodule // lsb_host_model
`default_nettype wire

// ==== bench/lsb_status_bank_test.sv ====
// Self-checking bench for the status and fault bank.
// Assumes the host model drives the register strobes.
`timescale 1ns/100ps
`default_nettype none
module lsb_status_bank_test;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic rx_in = 1'b1, rx_busy = 1'b1, otp = 1'b0, done_p = 1'b0, dec = 1'b1, slow = 1'b0;
  logic pump = 1'b0, shdn = 1'b0, warn = 1'b0, ok;
  logic [5:0] ev = 6'h00;
  logic [3:0] grade = 4'h0;
  logic [7:0] therm = 8'hA5;
  logic [11:0] open_d = 12'h000, short_d = 12'h000, slew = 12'h000;
  logic [143:0] duty;
  logic [12:0] rdata, wdata;
  logic [5:0] addr;
  logic wr, rd, rvalid, fault_n, crc_rej, idle_s;
  int errors = 0, total_checks = 0, k;
  lsb_status_bank #(.BIT_CYCLES(16'd4), .IDLE_UNIT(24'd8)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .rx_in(rx_in),
    .frame_crc_bad(ev[5]), .sync_parity_bad(ev[4]), .payload_parity_bad(ev[3]),
    .sync_stop_bad(ev[2]), .payload_stop_bad(ev[1]), .payload_start_bad(ev[0]),
    .otp_crc_mismatch(otp), .setup_prog_done(done_p), .grade_decode_done(dec),
    .grade_code(grade), .ext_ref_slow(slow), .pump_voltage_low(pump),
    .overheat_shutdown(shdn), .overheat_warning(warn), .open_detect(open_d),
    .short_detect(short_d), .slew_busy(slew), .duty_flat(duty),
    .thermistor_ratio(therm), .group_a_members(12'h005), .group_b_members(12'h800),
    .fault_out_n(fault_n), .crc_reject(crc_rej), .idle_safe_state(idle_s)
  );
  lsb_host_model u_host (
    .mclk(mclk), .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata)
  );
  always #5 mclk = ~mclk;
  // Line chatter keeps both idle timers quiet until a test stops it
  always @(posedge mclk) if (rx_busy) rx_in <= ~rx_in;
  task automatic compare(input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [12:0] m, input logic [12:0] exp);
    logic [12:0] d;
    logic got;
    u_host.rd(a, d, got);
    if (got !== 1'b1) d = 13'hxxxx;
    compare(d & m, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic fchk(input logic exp);
    compare({12'h000, fault_n}, {12'h000, exp});
  endtask
  task automatic wrap_up;
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #800000;
    errors++;
    wrap_up;
  end
  initial begin
    // Switch 3 just below the threshold, the rest exactly on it
    for (k = 0; k < 12; k++) duty[k*12 +: 12] = (k == 3) ? 12'h00F : 12'h010;
    tick(3);
    reset_n <= 1'b1;
    tick(4);
    rchk(6'h11, 13'h1FFF, 13'h0000);
    rchk(6'h12, 13'h1FFF, 13'h0000);
    rchk(6'h13, 13'h1FFF, 13'h0000);
    rchk(6'h16, 13'h1FFF, 13'h0010);
    rchk(6'h20, 13'h03FF, 13'h0100);
    rchk(6'h10, 13'h0403, 13'h0000);
    fchk(1'b1);
    u_host.wr(6'h15, 13'h1FFF);
    rchk(6'h15, 13'h1FFF, 13'h00A5);
    @(posedge mclk) therm <= 8'h3C;
    rchk(6'h15, 13'h1FFF, 13'h003C);
    for (k = 0; k < 6; k++) begin
      @(posedge mclk) ev <= 6'h01 << k;
      @(posedge mclk) ev <= 6'h00;
      #1 compare({12'h000, crc_rej}, {12'h000, k == 5});
      rchk(6'h11, 13'h1FFF, 13'h0002 << k);
      rchk(6'h10, 13'h0040, 13'h0040);
      u_host.wr(6'h11, 13'h0002 << k);
      rchk(6'h11, 13'h1FFF, 13'h0000);
    end
    rchk(6'h10, 13'h0040, 13'h0000);
    @(posedge mclk) {short_d, slew, open_d} <= {12'hFFF, 12'h001, 12'h801};
    tick(4);
    @(posedge mclk) {short_d, slew} <= 24'h0000_00;
    rchk(6'h12, 13'h1FFF, 13'h0FF6);
    rchk(6'h10, 13'h0018, 13'h0018);
    fchk(1'b0);
    u_host.wr(6'h12, 13'h0FF6);
    u_host.wr(6'h13, 13'h0FFF);
    rchk(6'h12, 13'h1FFF, 13'h0000);
    rchk(6'h13, 13'h1FFF, 13'h0801);
    @(posedge mclk) open_d <= 12'h000;
    u_host.wr(6'h0C, 13'h0010);
    tick(3);
    fchk(1'b1);
    u_host.wr(6'h0C, 13'h0000);
    u_host.wr(6'h0D, 13'h0801);
    tick(3);
    fchk(1'b1);
    u_host.wr(6'h0D, 13'h0000);
    tick(3);
    fchk(1'b0);
    u_host.wr(6'h13, 13'h0801);
    rchk(6'h10, 13'h0018, 13'h0000);
    @(posedge mclk) {shdn, warn} <= 2'b11;
    tick(4);
    @(posedge mclk) {shdn, warn} <= 2'b00;
    tick(4);
    rchk(6'h10, 13'h0003, 13'h0003);
    u_host.wr(6'h10, 13'h0002);
    rchk(6'h10, 13'h0003, 13'h0001);
    fchk(1'b0);
    u_host.wr(6'h10, 13'h0001);
    rchk(6'h10, 13'h0003, 13'h0000);
    @(posedge mclk) pump <= 1'b1;
    tick(10);
    rchk(6'h10, 13'h0004, 13'h0004);
    @(posedge mclk) pump <= 1'b0;
    tick(10);
    rchk(6'h10, 13'h0004, 13'h0000);
    @(posedge mclk) {dec, grade} <= 5'h09;
    tick(4);
    rchk(6'h10, 13'h0100, 13'h0100);
    fchk(1'b0);
    @(posedge mclk) dec <= 1'b1;
    tick(4);
    rchk(6'h10, 13'h0100, 13'h0000);
    rchk(6'h0F, 13'h000F, 13'h0009);
    @(posedge mclk) otp <= 1'b1;
    tick(4);
    @(posedge mclk) otp <= 1'b0;
    tick(4);
    rchk(6'h10, 13'h0400, 13'h0400);
    fchk(1'b1);
    @(posedge mclk) slow <= 1'b1;
    for (k = 1; k < 4; k++) begin
      u_host.setup_wr(13'(k << 4), ok);
      compare({12'h000, ok}, 13'h0001);
      rchk(6'h10, 13'h0200, 13'h0200);
      @(posedge mclk) done_p <= 1'b1;
      @(posedge mclk) done_p <= 1'b0;
      rchk(6'h10, 13'h0280, {5'h00, k[1], 7'h00});
    end
    @(posedge mclk) slow <= 1'b0;
    u_host.wr(6'h01, 13'h000A);
    @(posedge mclk) rx_busy <= 1'b0;
    tick(150);
    rchk(6'h11, 13'h0180, 13'h0180);
    compare({12'h000, idle_s}, 13'h0001);
    @(posedge mclk) rx_busy <= 1'b1;
    tick(6);
    compare({12'h000, idle_s}, 13'h0000);
    u_host.wr(6'h11, 13'h0180);
    rchk(6'h11, 13'h0180, 13'h0000);
    u_host.wr(6'h20, 13'h0311);
    u_host.wr(6'h20, 13'h0077);
    rchk(6'h21, 13'h00FF, 13'h0011);
    rchk(6'h2C, 13'h00FF, 13'h0011);
    u_host.wr(6'h20, 13'h025A);
    rchk(6'h2C, 13'h00FF, 13'h005A);
    rchk(6'h23, 13'h00FF, 13'h0011);
    u_host.wr(6'h20, 13'h01C3);
    rchk(6'h20, 13'h03FF, 13'h01C3);
    rchk(6'h23, 13'h00FF, 13'h00C3);
    rchk(6'h2C, 13'h00FF, 13'h005A);
    u_host.wr(6'h3F, 13'h1FFF);
    rchk(6'h3F, 13'h1FFF, 13'h0000);
    wrap_up;
  end
endmodule // lsb_status_bank_test
`default_nettype wire
